// ==== design/swbm_apb.sv ====
`timescale 1ns/10ps
module swbm_apb (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  output logic wr_o,
  output logic rd_o,
  output logic err_o
);
  import swbm_pkg::*;
  logic hit;
  // Zero wait states; unmapped address answers pslverr
  always_comb begin
    hit = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_DIV);
    wr_o = psel_i && penable_i && pwrite_i && hit;
    rd_o = psel_i && !penable_i && !pwrite_i && hit;
    err_o = psel_i && !penable_i && !hit;
  end
endmodule

// ==== design/swbm_pkg.sv ====
package swbm_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam logic [7:0] DIV_RST = 8'hfa;
  localparam int unsigned T_RST_LOW_US = 511;
  localparam int unsigned T_PRES_SAMPLE_US = 68;
  localparam int unsigned T_RST_HIGH_US = 512;
  localparam int unsigned T_ZERO_LOW_US = 100;
  localparam int unsigned T_SLOT_US = 117;
  localparam int unsigned T_SHORT_LOW_US = 5;
  localparam int unsigned T_READ_SAMPLE_US = 13;
  localparam logic [9:0] CNT_RST_LOW = 10'(T_RST_LOW_US);
  localparam logic [9:0] CNT_PRES = 10'(T_PRES_SAMPLE_US);
  localparam logic [9:0] CNT_RST_HIGH = 10'(T_RST_HIGH_US);
  localparam logic [9:0] CNT_ZERO_LOW = 10'(T_ZERO_LOW_US);
  localparam logic [9:0] CNT_SLOT = 10'(T_SLOT_US);
  localparam logic [9:0] CNT_SHORT_LOW = 10'(T_SHORT_LOW_US);
  localparam logic [9:0] CNT_READ_SMP = 10'(T_READ_SAMPLE_US);
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_DIV = 12'h004;
  localparam int unsigned CTRL_RPP_BIT = 0;
  localparam int unsigned CTRL_W0_BIT = 1;
  localparam int unsigned CTRL_W1R_BIT = 2;
  localparam int unsigned CTRL_PRES_BIT = 3;
  localparam int unsigned CTRL_RDV_BIT = 4;
  typedef enum logic [5:0] {
    SWBM_IDLE = 6'h01,
    SWBM_RLOW = 6'h02,
    SWBM_RHIGH = 6'h04,
    SWBM_ZLOW = 6'h08,
    SWBM_SLOW = 6'h10,
    SWBM_REST = 6'h20
  } swbm_state_t;
endpackage

// ==== design/swbm_tick.sv ====
`timescale 1ns/10ps
module swbm_tick (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] div_i,
  output logic tick_o
);
  logic [7:0] cnt_r;
  // [RULE14] Integer divide
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 8'h00;
      tick_o <= 1'b0;
    end else if (cnt_r + 8'h01 >= div_i) begin
      cnt_r <= 8'h00;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick_o <= 1'b0;
    end
  end
endmodule

// ==== design/swbm_top.sv ====
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] Presence flag set if slave answered reset, cleared otherwise.
// [RULE2] Write-zero slot lasts 117 us with line low 100 us.
// [RULE3] Write-zero command starts slot, self-clears when slot ends.
// [RULE4] Write-one and read slots share timing: short low then release.
// [RULE5] Slave holds line low after falling edge to return a zero.
// [RULE6] Write-one/read command starts slot, self-clears when done.
// [RULE7] Read value loaded with line level sampled in the slot.
// [RULE8] Reset low held 511 us, never below 480 us.
// [RULE9] Presence sampled 68 us after reset release.
// [RULE10] Recovery high 512 us before any further slot.
// [RULE11] Short low pulse lasts 5 us.
// [RULE12] Read sample taken 13 us after slot falling edge.
// [RULE13] Phases sequenced by state machine on tick counts.
// [RULE14] Tick from integer divide of main clock.
// [RULE15] Integrator keeps tick error within 0.0645; no integrator here, the tick is a plain integer divide.
// [RULE16] Main clock not below 10 MHz.
// [RULE17] Reset command starts reset, self-clears after presence phase.
// [RULE18] Slave answers 15-60 us after rise, low 60-240 us.
// [RULE19] Line only pulled low; one slot at a time.
// [RULE20] Divide ratio is software programmable.
module swbm_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe_o
);
  import swbm_pkg::*;
  swbm_state_t state_r;
  logic [9:0] cnt_r;
  logic [7:0] div_r;
  logic reset_presence_cmd_r;
  logic write_zero_cmd_r;
  logic write_one_read_cmd_r;
  logic presence_detected_r;
  logic read_bit_value_r;
  logic tick;
  logic wr;
  logic rd;
  logic err;
  logic busy;
  logic done;
  logic [9:0] cnt_nxt;

  swbm_tick u_tick (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .div_i(div_r),
    .tick_o(tick)
  );

  swbm_apb u_apb (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .wr_o(wr),
    .rd_o(rd),
    .err_o(err)
  );

  assign busy = (state_r != SWBM_IDLE);
  assign cnt_nxt = cnt_r + 10'h001;
  assign done = tick && (((state_r == SWBM_RHIGH) && (cnt_nxt == CNT_RST_HIGH))
    || ((state_r == SWBM_REST) && (cnt_nxt == CNT_SLOT)));

  // Ready in access phase; answer same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= 1'b1;
      // Decoded in setup so the flag stands in access
      pslverr_o <= err;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd) begin
      prdata_o <= 32'h0000_0000;
      if (paddr_i == ADDR_DIV) begin
        prdata_o[7:0] <= div_r;
      end else begin
        prdata_o[CTRL_RPP_BIT] <= reset_presence_cmd_r;
        prdata_o[CTRL_W0_BIT] <= write_zero_cmd_r;
        prdata_o[CTRL_W1R_BIT] <= write_one_read_cmd_r;
        prdata_o[CTRL_PRES_BIT] <= presence_detected_r;
        prdata_o[CTRL_RDV_BIT] <= read_bit_value_r;
      end
    end
  end

  // [RULE20] Divider from software
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r <= DIV_RST;
    end else if (wr && (paddr_i == ADDR_DIV) && (pwdata_i[7:0] != 8'h00)) begin
      div_r <= pwdata_i[7:0];
    end
  end

  // Commands; writes while busy ignored, done clears
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reset_presence_cmd_r <= 1'b0;
      write_zero_cmd_r <= 1'b0;
      write_one_read_cmd_r <= 1'b0;
    end else if (done) begin
      // [RULE3] [RULE6] [RULE17] Self clear
      reset_presence_cmd_r <= 1'b0;
      write_zero_cmd_r <= 1'b0;
      write_one_read_cmd_r <= 1'b0;
    end else if (wr && (paddr_i == ADDR_CTRL) && !busy
                 && !reset_presence_cmd_r && !write_zero_cmd_r && !write_one_read_cmd_r) begin
      // [RULE19] One slot at a time, priority reset
      if (pwdata_i[CTRL_RPP_BIT]) begin
        reset_presence_cmd_r <= 1'b1;
      end else if (pwdata_i[CTRL_W0_BIT]) begin
        write_zero_cmd_r <= 1'b1;
      end else if (pwdata_i[CTRL_W1R_BIT]) begin
        write_one_read_cmd_r <= 1'b1;
      end
    end
  end

  // [RULE13] Tick-counted sequencer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= SWBM_IDLE;
      cnt_r <= 10'h000;
    end else begin
      case (state_r)
        SWBM_IDLE: begin
          cnt_r <= 10'h000;
          if (reset_presence_cmd_r) begin
            state_r <= SWBM_RLOW;
          end else if (write_zero_cmd_r) begin
            state_r <= SWBM_ZLOW;
          end else if (write_one_read_cmd_r) begin
            state_r <= SWBM_SLOW;
          end
        end
        SWBM_RLOW: begin
          // [RULE8] Reset low length
          if (tick) begin
            cnt_r <= (cnt_nxt == CNT_RST_LOW) ? 10'h000 : cnt_nxt;
            if (cnt_nxt == CNT_RST_LOW) begin
              state_r <= SWBM_RHIGH;
            end
          end
        end
        SWBM_RHIGH: begin
          // [RULE10] Recovery before next slot
          if (tick) begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt == CNT_RST_HIGH) begin
              state_r <= SWBM_IDLE;
            end
          end
        end
        SWBM_ZLOW: begin
          // [RULE2] Zero low phase
          if (tick) begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt == CNT_ZERO_LOW) begin
              state_r <= SWBM_REST;
            end
          end
        end
        SWBM_SLOW: begin
          // [RULE4] [RULE11] Short low then release
          if (tick) begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt == CNT_SHORT_LOW) begin
              state_r <= SWBM_REST;
            end
          end
        end
        SWBM_REST: begin
          if (tick) begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt == CNT_SLOT) begin
              state_r <= SWBM_IDLE;
            end
          end
        end
        default: begin
          state_r <= SWBM_IDLE;
          cnt_r <= 10'h000;
        end
      endcase
    end
  end

  // [RULE19] Drive low only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_oe_o <= 1'b0;
    end else begin
      line_oe_o <= (state_r == SWBM_RLOW) || (state_r == SWBM_ZLOW) || (state_r == SWBM_SLOW);
    end
  end
  // [RULE19] Data level fixed low
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_o <= 1'b0;
    end else begin
      line_o <= 1'b0;
    end
  end

  // [RULE1] [RULE9] Presence sample
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      presence_detected_r <= 1'b0;
    end else if ((state_r == SWBM_RHIGH) && tick && (cnt_nxt == CNT_PRES)) begin
      presence_detected_r <= !line_i;
    end
  end

  // [RULE7] [RULE12] Read sample; relies on slave holding low [RULE5]
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      read_bit_value_r <= 1'b0;
    end else if (write_one_read_cmd_r && (state_r == SWBM_REST) && tick
                 && (cnt_nxt == CNT_READ_SMP)) begin
      read_bit_value_r <= line_i;
    end
  end

  logic [9:0] low_len_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_len_r <= 10'h000;
    end else if (state_r == SWBM_IDLE) begin
      low_len_r <= 10'h000;
    end else if (state_r == SWBM_RLOW && tick) begin
      low_len_r <= low_len_r + 10'h001;
    end
  end

  // Each start is one idle cycle with a command pending
  sequence s_zero_start;
    (state_r == SWBM_IDLE) && write_zero_cmd_r && !reset_presence_cmd_r;
  endsequence

  sequence s_w1r_start;
    (state_r == SWBM_IDLE) && write_one_read_cmd_r && !reset_presence_cmd_r
      && !write_zero_cmd_r;
  endsequence

  sequence s_rpp_start;
    (state_r == SWBM_IDLE) && reset_presence_cmd_r;
  endsequence

  // [RULE2] Zero low length
  a_zero_low_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE2]
    $fell(state_r == SWBM_ZLOW) |-> cnt_r == CNT_ZERO_LOW)
    else $error("zero low phase wrong length");
  // [RULE2] Zero slot length
  a_zero_slot_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE2]
    $fell(write_zero_cmd_r) |-> $past(cnt_r) == CNT_SLOT - 10'h001)
    else $error("write zero slot wrong length");
  // [RULE3] Zero clears at end
  a_zero_cmd_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE3]
    $fell(write_zero_cmd_r) |-> $past(state_r) == SWBM_REST && state_r == SWBM_IDLE)
    else $error("write zero cleared early");
  // [RULE3] Zero slot starts
  a_zero_start: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE3]
    s_zero_start |=> state_r == SWBM_ZLOW ##1 line_oe_o)
    else $error("write zero did not start");
  // [RULE6] Combined slot starts
  a_w1r_start: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE6]
    s_w1r_start |=> state_r == SWBM_SLOW ##1 line_oe_o)
    else $error("write one read did not start");
  // [RULE6] Combined clears at end
  a_w1r_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE6]
    $fell(write_one_read_cmd_r) |-> $past(cnt_r) == CNT_SLOT - 10'h001)
    else $error("write one read cleared early");
  // [RULE4] Released after low
  a_slot_release: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE4]
    (state_r == SWBM_REST) && ($past(state_r) == SWBM_REST) |-> !line_oe_o)
    else $error("line held during slot rest");
  // [RULE11] Short low length
  a_short_low_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE11]
    $fell(state_r == SWBM_SLOW) |-> cnt_r == CNT_SHORT_LOW)
    else $error("short low wrong length");
  // [RULE7] Read value loaded
  a_read_value: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE7]
    write_one_read_cmd_r && (state_r == SWBM_REST) && tick && (cnt_nxt == CNT_READ_SMP)
    |=> read_bit_value_r == $past(line_i))
    else $error("read value not loaded");
  // [RULE12] Read sample point
  a_read_point: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE12]
    $changed(read_bit_value_r) |-> $past(write_one_read_cmd_r)
    && ($past(cnt_r) == CNT_READ_SMP - 10'h001))
    else $error("read value changed off sample point");
  // [RULE8] Reset low length
  a_reset_low_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE8]
    $fell(state_r == SWBM_RLOW) |-> low_len_r == CNT_RST_LOW)
    else $error("reset low wrong length");
  // [RULE17] Reset sequence starts
  a_rpp_start: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE17]
    s_rpp_start |=> state_r == SWBM_RLOW ##1 line_oe_o)
    else $error("reset pulse did not start");
  // [RULE1] Presence from line
  a_pres_value: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE1]
    (state_r == SWBM_RHIGH) && tick && (cnt_nxt == CNT_PRES)
    |=> presence_detected_r == !$past(line_i))
    else $error("presence flag not loaded");
  // [RULE9] Presence sample point
  a_pres_point: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE9]
    $changed(presence_detected_r) |-> ($past(state_r) == SWBM_RHIGH)
    && ($past(cnt_r) == CNT_PRES - 10'h001))
    else $error("presence changed off sample point");
  // [RULE10] Recovery length
  a_recovery_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE10]
    $fell(state_r == SWBM_RHIGH) |-> $past(cnt_r) == CNT_RST_HIGH - 10'h001)
    else $error("recovery wrong length");
  // [RULE10] Recovery line released
  a_recovery_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE10]
    (state_r == SWBM_RHIGH) && ($past(state_r) == SWBM_RHIGH) |-> !line_oe_o)
    else $error("line held during recovery");
  // [RULE17] Reset clears at end
  a_rpp_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE17]
    $fell(reset_presence_cmd_r) |-> $past(cnt_r) == CNT_RST_HIGH - 10'h001)
    else $error("reset command cleared early");
  // [RULE14] Tick one cycle wide
  a_tick_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE14]
    tick && (div_r != 8'h01) |=> !tick)
    else $error("tick wider than one cycle");
  // [RULE19] One command pending
  a_one_cmd: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE19]
    $onehot0({reset_presence_cmd_r, write_zero_cmd_r, write_one_read_cmd_r}))
    else $error("more than one command pending");
  // [RULE19] Busy writes dropped
  a_busy_drop: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE19]
    wr && (paddr_i == ADDR_CTRL) && !done && (busy || reset_presence_cmd_r
    || write_zero_cmd_r || write_one_read_cmd_r)
    |=> $stable({reset_presence_cmd_r, write_zero_cmd_r, write_one_read_cmd_r}))
    else $error("command accepted while busy");
  // [RULE19] Idle line released
  a_idle_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE19]
    (state_r == SWBM_IDLE) && ($past(state_r) == SWBM_IDLE) |-> !line_oe_o)
    else $error("line held while idle");
  // [RULE19] Low level only
  a_line_low_only: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE19]
    line_oe_o |-> !line_o)
    else $error("line driven high");
endmodule

// ==== tb/swbm_slave_model.sv ====
`timescale 1ns/10ps
module swbm_slave_model #(
  parameter int TICK = 2
) (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic present_i,
  input wire logic bit_i,
  output logic pull_o
);
  int low_cnt = 0;
  int wait_cnt = 0;
  int pull_cnt = 0;
  logic line_d = 1'b1;
  assign pull_o = (pull_cnt > 0);
  always @(posedge clk_i) begin
    line_d <= line_i;
    low_cnt <= line_i ? 0 : low_cnt + 1;
    if (pull_cnt > 0) begin
      pull_cnt <= pull_cnt - 1;
    end
    if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
      if (wait_cnt == 1) begin
        pull_cnt <= 120 * TICK;
      end
    end
    if (line_i && !line_d && low_cnt >= 400 * TICK && present_i) begin
      wait_cnt <= 30 * TICK;
    end
    // zero held past master release; own pull is no slot
    if (!line_i && line_d && !bit_i && present_i && pull_cnt == 0) begin
      pull_cnt <= 30 * TICK;
    end
  end
endmodule

// ==== tb/test_single_wire_bus_master.sv ====
`timescale 1ns/10ps
module test_single_wire_bus_master;
  import swbm_pkg::*;
  localparam int T = 2;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic line_o;
  logic line_oe;
  logic pull;
  logic present = 1'b1;
  logic sbit = 1'b1;
  logic [31:0] rv;
  logic er;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_rel = 0;
  // Pull-up: released line floats high
  wire line = ~(line_oe | pull);
  // main clock far above 10 MHz
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  swbm_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .line_i(line), .line_o(line_o),
    .line_oe_o(line_oe));
  swbm_slave_model #(.TICK(T)) slave (.clk_i(clk_i), .line_i(line),
    .present_i(present), .bit_i(sbit), .pull_o(pull));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rng(input string what, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    // No bound on this wait: pready high ends it, otherwise the bench timeout
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Low time of the master's pull, in clocks
  task automatic pulse(input int lo, input int hi);
    int n;
    int len;
    n = 0;
    len = 0;
    while (line_oe !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    while (line_oe === 1'b1 && len < 2000) begin
      chk("line_o", 32'h0, {31'h0, line_o});
      @(posedge clk_i);
      len++;
    end
    t_rel = cyc;
    rng("low_time", lo, hi, len);
  endtask
  // Polls until the command bit drops; time taken from line release
  task automatic wait_clr(input int b, input int lo, input int hi);
    int n;
    n = 0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    while (rv[b] !== 1'b0 && n < 1000) begin
      apb(1'b0, ADDR_CTRL, 32'h0);
      n++;
    end
    rng("clear_time", lo, hi, cyc - t_rel);
  endtask
  task automatic s_regs();
    apb(1'b0, ADDR_DIV, 32'h0);
    chk("div_reset", {24'h0, DIV_RST}, rv);
    chk("mapped_err", 32'h0, {31'h0, er});
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0, {29'h0, rv[2:0]});
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    // exact integer ratio, no tick error
    apb(1'b1, ADDR_DIV, 32'(T));
    apb(1'b0, ADDR_DIV, 32'h0);
    chk("div_value", 32'(T), rv);
    // Zero ratio refused, old value kept
    apb(1'b1, ADDR_DIV, 32'h0);
    apb(1'b0, ADDR_DIV, 32'h0);
    chk("div_zero_kept", 32'(T), rv);
  endtask
  task automatic s_reset(input logic pres);
    present <= pres;
    apb(1'b1, ADDR_CTRL, 32'h1);
    pulse(510 * T, 512 * T);
    // Busy: this write must be dropped
    apb(1'b1, ADDR_CTRL, 32'h2);
    wait_clr(CTRL_RPP_BIT, 511 * T - 2, 514 * T + 8);
    chk("presence", {31'h0, pres}, {31'h0, rv[CTRL_PRES_BIT]});
    chk("cmd_bits", 32'h0, {30'h0, rv[2:1]});
  endtask
  task automatic s_zero();
    apb(1'b1, ADDR_CTRL, 32'h2);
    pulse(99 * T, 101 * T);
    wait_clr(CTRL_W0_BIT, 16 * T - 2, 19 * T + 8);
  endtask
  task automatic s_read(input logic b);
    present <= 1'b1;
    sbit <= b;
    apb(1'b1, ADDR_CTRL, 32'h4);
    pulse(4 * T, 6 * T);
    wait_clr(CTRL_W1R_BIT, 111 * T - 2, 114 * T + 8);
    chk("read_bit", {31'h0, b}, {31'h0, rv[CTRL_RDV_BIT]});
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    s_regs();
    s_reset(1'b1);
    s_reset(1'b0);
    s_zero();
    s_read(1'b0);
    s_read(1'b1);
    test_done();
  end
endmodule
